// ### common/timer_out_pkg.sv
// Operation
// - Grand total accumulates run time separately.
// - Ten second two-button hold clears grand total.
// - Contact closed 1s or 2ms resets timer.
// - Turn-on state sets, turn-off state clears output.
// - Five timer states selectable for on/off.
// - Inverted selection matches any other state.
// - Enable off holds output off, settings kept.
// - Turn-on delay 0 to 32400 seconds.
// - Status indicator follows status output.
// - Control output 1 has independent settings.
// - Output-1 indicator follows control output 1.
// - Control output 1 turn-on delay, 1s steps.
// - Control output 2 identical, independent settings.
// - Three second two-button hold resets timer.
`default_nettype none
package timer_out_pkg;
    // Clock rate and derived cycle counts
    localparam int CLOCK_HZ = 25_000_000;
    localparam int SEC_CYCLES = CLOCK_HZ;
    localparam int SLOW_QUALIFY_MS = 1000;
    localparam int FAST_QUALIFY_MS = 2;
    localparam int SLOW_QUALIFY_CYCLES = CLOCK_HZ / 1000 * SLOW_QUALIFY_MS;
    localparam int FAST_QUALIFY_CYCLES = CLOCK_HZ / 1000 * FAST_QUALIFY_MS;
    localparam int LOCAL_RESET_HOLD_S = 3;
    localparam int GRAND_CLEAR_HOLD_S = 10;
    localparam int LOCAL_RESET_HOLD_CYCLES = CLOCK_HZ * LOCAL_RESET_HOLD_S;
    localparam int GRAND_CLEAR_HOLD_CYCLES = CLOCK_HZ * GRAND_CLEAR_HOLD_S;
    // Longest turn-on delay in seconds
    localparam logic [14:0] DELAY_MAX_S = 15'h7E90;
    // Value of every state register after reset
    localparam logic [14:0] DELAY_RESET = 15'h0000;

    // Timer states reported by the timing core
    typedef enum logic [2:0] {
        reset_state = 3'h0,
        running_state = 3'h1,
        paused_state = 3'h2,
        restart_delay_state = 3'h3,
        complete_state = 3'h4
    } timer_state_t;

    // One trigger selection, invert picks the n states
    typedef struct packed {
        logic invert;
        timer_state_t state;
    } trigger_t;

    // Settings of one switched output
    typedef struct packed {
        logic enable;
        trigger_t on_at;
        trigger_t off_at;
        logic [14:0] delay_s;
    } out_cfg_t;

    // State of one switched output
    typedef struct packed {
        logic active;
        logic pending;
        logic [14:0] remain;
        logic out;
    } switch_state_t;

    // State of the top module
    typedef struct packed {
        logic [1:0] contact_sync;
        logic [1:0] btn_a_sync;
        logic [1:0] btn_b_sync;
        timer_state_t prev_state;
        logic [24:0] sec_cnt;
        logic sec_tick;
        logic [24:0] run_cnt;
        logic [31:0] grand_total;
        logic [24:0] contact_cnt;
        logic [27:0] hold_cnt;
        logic reset_request;
    } top_state_t;
endpackage : timer_out_pkg
`default_nettype wire

// ### src/switched_output.sv
`timescale 1ns/10ps
`default_nettype none
module switched_output (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Timing events
    input wire logic sec_tick,
    input wire logic entered,
    input wire timer_out_pkg::timer_state_t state,
    // Settings
    input wire timer_out_pkg::out_cfg_t cfg,
    // Switched output
    output logic out
);
    // Whole state of this output
    timer_out_pkg::switch_state_t st;
    timer_out_pkg::switch_state_t next_st;
    // Trigger matches for the state just entered
    logic on_hit;
    logic off_hit;
    // Delay clamped to its legal top
    logic [14:0] delay;

    // Selection match, inverted selection matches all other states
    assign on_hit = (state == cfg.on_at.state) ^ cfg.on_at.invert;
    assign off_hit = (state == cfg.off_at.state) ^ cfg.off_at.invert;
    assign delay = (cfg.delay_s > timer_out_pkg::DELAY_MAX_S) ?
                   timer_out_pkg::DELAY_MAX_S : cfg.delay_s;

    // Next state of the output
    always_comb
    begin
        next_st = st;
        if (entered && off_hit)
        begin
            // Turn-off wins and drops any pending turn-on
            next_st.active = 1'b0;
            next_st.pending = 1'b0;
        end
        else if (entered && on_hit && !st.active && !st.pending)
        begin
            // Zero delay switches on at once
            if (delay == timer_out_pkg::DELAY_RESET)
            begin
                next_st.active = 1'b1;
            end
            else
            begin
                next_st.pending = 1'b1;
                next_st.remain = delay;
            end
        end
        else if (st.pending && sec_tick)
        begin
            // First step may be short, ticks are free running
            next_st.remain = st.remain - 15'h0001;
            if (st.remain == 15'h0001)
            begin
                next_st.pending = 1'b0;
                next_st.active = 1'b1;
            end
        end
        // Enable gates only the pin, settings and state are kept
        next_st.out = next_st.active & cfg.enable;
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign out = st.out;

    // Disabled output never drives
    property p_disabled_off;
        @(posedge clock) disable iff (!rst_n)
        !cfg.enable |=> !out;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("output on while disabled");

    // Turn-off entry cancels and clears
    property p_off_cancels;
        @(posedge clock) disable iff (!rst_n)
        entered && off_hit |=> !out && !st.pending;
    endproperty
    a_off_cancels: assert property (p_off_cancels)
        else $error("turn-off did not cancel output");

    // Zero delay turns on next cycle
    property p_zero_delay_on;
        @(posedge clock) disable iff (!rst_n)
        entered && on_hit && !off_hit && cfg.enable && !st.active && !st.pending
            && cfg.delay_s == 15'h0000 |=> out;
    endproperty
    a_zero_delay_on: assert property (p_zero_delay_on)
        else $error("output not on after zero delay");

    // Non-zero delay holds the output off first
    property p_delay_holds;
        @(posedge clock) disable iff (!rst_n)
        entered && on_hit && !off_hit && !st.active && !st.pending
            && cfg.delay_s != 15'h0000 |=> !st.active && st.pending;
    endproperty
    a_delay_holds: assert property (p_delay_holds)
        else $error("delay skipped");
endmodule : switched_output
`default_nettype wire

// ### src/timer_state_output_control.sv
`timescale 1ns/10ps
`default_nettype none
module timer_state_output_control #(
    // Long counts, shortened in simulation
    parameter logic [24:0] SEC_CYCLES = 25'(timer_out_pkg::SEC_CYCLES),
    parameter logic [24:0] SLOW_QUALIFY_CYCLES =
        25'(timer_out_pkg::SLOW_QUALIFY_CYCLES),
    parameter logic [24:0] FAST_QUALIFY_CYCLES =
        25'(timer_out_pkg::FAST_QUALIFY_CYCLES),
    parameter logic [27:0] LOCAL_RESET_HOLD_CYCLES =
        28'(timer_out_pkg::LOCAL_RESET_HOLD_CYCLES),
    parameter logic [27:0] GRAND_CLEAR_HOLD_CYCLES =
        28'(timer_out_pkg::GRAND_CLEAR_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,

    // Timer state from the timing core
    input wire timer_out_pkg::timer_state_t timer_state,

    // Pins: reset contact and front-panel buttons
    input wire logic reset_contact_closed,
    input wire logic button_a,
    input wire logic button_b,

    // Configuration bits
    input wire logic display_mode,
    input wire logic slow_reset_qualify,
    input wire logic local_reset_enable,
    input wire logic grand_clear_enable,
    input wire logic out1_fitted,
    input wire logic out2_fitted,

    // Output settings
    input wire timer_out_pkg::out_cfg_t status_cfg,
    input wire timer_out_pkg::out_cfg_t out1_cfg,
    input wire timer_out_pkg::out_cfg_t out2_cfg,

    // Switched outputs
    output logic status_output,
    output logic control_out_1,
    output logic control_out_2,

    // Display indicators
    output logic status_indicator,
    output logic out1_indicator,
    output logic out2_indicator,

    // Timer reset request and run-time total
    output logic timer_reset_request,
    output logic [31:0] grand_total
);
    // Whole state of the top module
    timer_out_pkg::top_state_t st;
    timer_out_pkg::top_state_t next_st;

    // Timer has moved to another state this cycle
    logic entered;

    // Both buttons held together in display mode
    logic both_held;

    // Qualification count for the chosen mode
    logic [24:0] qualify_cycles;

    // Settings as seen by the fitted outputs
    timer_out_pkg::out_cfg_t out1_eff;
    timer_out_pkg::out_cfg_t out2_eff;

    // Per-output switched levels
    logic status_level;
    logic out1_level;
    logic out2_level;

    // Entry is a change of the reported state
    assign entered = (timer_state != st.prev_state);

    // Synchronised buttons only, first stages stay untouched
    assign both_held = st.btn_a_sync[1] & st.btn_b_sync[1] & display_mode;

    // Slow mode suits hand buttons, fast mode suits other outputs
    assign qualify_cycles = slow_reset_qualify ? SLOW_QUALIFY_CYCLES
                                               : FAST_QUALIFY_CYCLES;

    // An unfitted output is treated as disabled
    always_comb
    begin
        out1_eff = out1_cfg;
        out1_eff.enable = out1_cfg.enable & out1_fitted;
        out2_eff = out2_cfg;
        out2_eff.enable = out2_cfg.enable & out2_fitted;
    end

    // Next state of reset paths, tick and grand total
    always_comb
    begin
        next_st = st;

        // Two-stage synchronisers on the pins
        next_st.contact_sync = {st.contact_sync[0], reset_contact_closed};
        next_st.btn_a_sync = {st.btn_a_sync[0], button_a};
        next_st.btn_b_sync = {st.btn_b_sync[0], button_b};

        // Remember state for entry detection
        next_st.prev_state = timer_state;

        // Free-running one second tick for the delays
        next_st.sec_tick = 1'b0;
        if (st.sec_cnt == SEC_CYCLES - 25'h0000001)
        begin
            next_st.sec_cnt = 25'h0000000;
            next_st.sec_tick = 1'b1;
        end
        else
        begin
            next_st.sec_cnt = st.sec_cnt + 25'h0000001;
        end

        // Run time counts only while running, so pauses lose nothing
        if (timer_state == timer_out_pkg::running_state)
        begin
            if (st.run_cnt == SEC_CYCLES - 25'h0000001)
            begin
                next_st.run_cnt = 25'h0000000;
                next_st.grand_total = st.grand_total + 32'h00000001;
            end
            else
            begin
                next_st.run_cnt = st.run_cnt + 25'h0000001;
            end
        end

        // Request is a one-cycle pulse
        next_st.reset_request = 1'b0;

        // Contact must stay closed for the whole qualify time
        if (st.contact_sync[1])
        begin
            if (st.contact_cnt < qualify_cycles)
            begin
                next_st.contact_cnt = st.contact_cnt + 25'h0000001;
            end
            if (st.contact_cnt == qualify_cycles - 25'h0000001)
            begin
                next_st.reset_request = 1'b1;
            end
        end
        else
        begin
            // Any opening restarts qualification
            next_st.contact_cnt = 25'h0000000;
        end

        // Button hold timing, saturating past the longest hold
        if (both_held)
        begin
            if (st.hold_cnt <= GRAND_CLEAR_HOLD_CYCLES)
            begin
                next_st.hold_cnt = st.hold_cnt + 28'h0000001;
            end
            // Strictly longer than three seconds
            if (st.hold_cnt == LOCAL_RESET_HOLD_CYCLES && local_reset_enable)
            begin
                next_st.reset_request = 1'b1;
            end
            // Strictly longer than ten seconds, clear beats counting
            if (st.hold_cnt == GRAND_CLEAR_HOLD_CYCLES && grand_clear_enable)
            begin
                next_st.grand_total = 32'h00000000;
                next_st.run_cnt = 25'h0000000;
            end
        end
        else
        begin
            // Releasing either button restarts the hold
            next_st.hold_cnt = 28'h0000000;
        end
    end

    // State register
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // Status output
    switched_output u_status (
        .clock(clock),
        .rst_n(rst_n),
        .sec_tick(st.sec_tick),
        .entered(entered),
        .state(timer_state),
        .cfg(status_cfg),
        .out(status_level)
    );

    // Control output 1, own settings
    switched_output u_out1 (
        .clock(clock),
        .rst_n(rst_n),
        .sec_tick(st.sec_tick),
        .entered(entered),
        .state(timer_state),
        .cfg(out1_eff),
        .out(out1_level)
    );

    // Control output 2, same logic, own settings
    switched_output u_out2 (
        .clock(clock),
        .rst_n(rst_n),
        .sec_tick(st.sec_tick),
        .entered(entered),
        .state(timer_state),
        .cfg(out2_eff),
        .out(out2_level)
    );

    // Outputs straight from registers
    assign status_output = status_level;
    assign control_out_1 = out1_level;
    assign control_out_2 = out2_level;

    // Indicators share the output flops, so they never disagree
    assign status_indicator = status_level;
    assign out1_indicator = out1_level;
    assign out2_indicator = out2_level;

    assign timer_reset_request = st.reset_request;
    assign grand_total = st.grand_total;

    // No contact closure, no contact reset
    property p_contact_needs_closure;
        @(posedge clock) disable iff (!rst_n)
        !local_reset_enable && !st.contact_sync[1] |=> !timer_reset_request;
    endproperty
    a_contact_needs_closure: assert property (p_contact_needs_closure)
        else $error("reset without contact closure");

    // Grand total only steps up while running, or clears
    property p_grand_counts_run;
        @(posedge clock) disable iff (!rst_n)
        $changed(grand_total) |->
            grand_total == 32'h00000000 ||
            (grand_total == $past(grand_total) + 32'h00000001 &&
             $past(timer_state) == timer_out_pkg::running_state);
    endproperty
    a_grand_counts_run: assert property (p_grand_counts_run)
        else $error("grand total moved wrongly");

    // No clear while the grand clear is off
    property p_grand_keep;
        @(posedge clock) disable iff (!rst_n)
        !grand_clear_enable && grand_total != 32'h00000000
            |=> grand_total != 32'h00000000;
    endproperty
    a_grand_keep: assert property (p_grand_keep)
        else $error("grand total cleared while disabled");

    // Status and output-1 indicators match their outputs
    property p_indicators_follow;
        @(posedge clock) disable iff (!rst_n)
        status_indicator == status_output && out1_indicator == control_out_1;
    endproperty
    a_indicators_follow: assert property (p_indicators_follow)
        else $error("indicator differs from output");

    // Three second hold with local reset on must request a reset
    property p_local_reset_fires;
        @(posedge clock) disable iff (!rst_n)
        both_held && st.hold_cnt == LOCAL_RESET_HOLD_CYCLES && local_reset_enable
            |=> timer_reset_request;
    endproperty
    a_local_reset_fires: assert property (p_local_reset_fires)
        else $error("button hold did not reset the timer");

    // Ten second hold with clear on must zero the total
    property p_grand_clear_fires;
        @(posedge clock) disable iff (!rst_n)
        both_held && st.hold_cnt == GRAND_CLEAR_HOLD_CYCLES && grand_clear_enable
            |=> grand_total == 32'h00000000;
    endproperty
    a_grand_clear_fires: assert property (p_grand_clear_fires)
        else $error("button hold did not clear the total");

    // Delay tick is a single-cycle enable, never a level
    property p_tick_single;
        @(posedge clock) disable iff (!rst_n)
        st.sec_tick |=> !st.sec_tick;
    endproperty
    a_tick_single: assert property (p_tick_single)
        else $error("second tick longer than one cycle");

    // An open contact throws away any partial qualification
    property p_open_restarts;
        @(posedge clock) disable iff (!rst_n)
        !st.contact_sync[1] |=> st.contact_cnt == 25'h0000000;
    endproperty
    a_open_restarts: assert property (p_open_restarts)
        else $error("contact count kept across an opening");
endmodule : timer_state_output_control
`default_nettype wire

// ### tb/contact_model.sv
`timescale 1ns/10ps
`default_nettype none
module contact_model (
    // Clock
    input wire logic clock,
    // Closure request from the bench
    input wire logic go,
    input wire logic [7:0] len,
    // Contact pin, high while closed
    output logic closed
);
    // Cycles of closure still to run
    logic [7:0] left = 8'h00;

    // Contact opens by itself; no bounce, so the closed time is exact
    always @(posedge clock)
    begin
        if (go)
            left <= len;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end

    // Closed while the count runs
    assign closed = (left != 8'h00);
endmodule : contact_model
`default_nettype wire

// ### tb/timer_state_output_control_bench.sv
`timescale 1ns/10ps
`default_nettype none
module timer_state_output_control_bench;
    // Stimulus, all valued at time zero
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    timer_out_pkg::timer_state_t ts = timer_out_pkg::reset_state;
    logic btn_a = 1'b0;
    logic btn_b = 1'b0;
    logic disp = 1'b1;
    logic slow_q = 1'b0;
    logic loc_en = 1'b1;
    logic gc_en = 1'b1;
    logic [1:0] fitted = 2'h3;
    timer_out_pkg::out_cfg_t cfg [3] = '{default: '0};
    logic [7:0] close_len = 8'h00;
    logic close_go = 1'b0;
    // Observed results
    logic contact;
    wire logic [2:0] outs;
    wire logic [2:0] inds;
    logic req;
    logic [31:0] total;
    int fails = 0;
    int comparisons = 0;
    int n;
    int c;

    // 25 MHz clock
    always #20 clock = ~clock;

    // Short counts keep the run brief: 1 s = 10 cycles
    timer_state_output_control #(.SEC_CYCLES(25'h000000A), .SLOW_QUALIFY_CYCLES(25'h0000014),
        .FAST_QUALIFY_CYCLES(25'h0000004), .LOCAL_RESET_HOLD_CYCLES(28'h000001E),
        .GRAND_CLEAR_HOLD_CYCLES(28'h0000064)) uut (.clock(clock), .rst_n(rst_n),
        .timer_state(ts), .reset_contact_closed(contact), .button_a(btn_a), .button_b(btn_b),
        .display_mode(disp), .slow_reset_qualify(slow_q), .local_reset_enable(loc_en),
        .grand_clear_enable(gc_en), .out1_fitted(fitted[0]), .out2_fitted(fitted[1]),
        .status_cfg(cfg[0]), .out1_cfg(cfg[1]), .out2_cfg(cfg[2]), .status_output(outs[0]),
        .control_out_1(outs[1]), .control_out_2(outs[2]), .status_indicator(inds[0]),
        .out1_indicator(inds[1]), .out2_indicator(inds[2]), .timer_reset_request(req),
        .grand_total(total));

    // Far side: reset contact wiring
    contact_model wiring (.clock(clock), .go(close_go), .len(close_len), .closed(contact));

    // Selection codes are {invert, state}
    function automatic timer_out_pkg::out_cfg_t mk(input logic [3:0] on_sel,
        input logic [3:0] off_sel, input logic [14:0] d);
        mk = {1'b1, on_sel, off_sel, d};
    endfunction : mk

    // State number wrapped into the five states
    function automatic timer_out_pkg::timer_state_t st(input int k);
        st = timer_out_pkg::timer_state_t'(3'(k % 5));
    endfunction : st

    task automatic stop_test();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t bit got %b expected %b", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_total(input logic [31:0] exp);
        comparisons++;
        if (total !== exp)
        begin
            fails++;
            $display("MISMATCH %0t total got %0d expected %0d", $time, total, exp);
        end
    endtask : check_total

    // Past the edge so registered outputs have settled
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step

    // Enter a state and allow the one-cycle answer
    task automatic go(input timer_out_pkg::timer_state_t s);
        @(posedge clock);
        ts <= s;
        step(3);
    endtask : go

    // Bounded wait; running out ends the run
    task automatic wait_out(input int idx, input logic v, input int lim, output int k);
        k = 0;
        while (outs[idx] !== v && k < lim)
        begin
            step(1);
            k++;
        end
        if (k >= lim)
        begin
            fails++;
            $display("MISMATCH %0t output %0d stuck", $time, idx);
            stop_test();
        end
    endtask : wait_out

    // Request stands one cycle, so it is sampled every cycle
    task automatic count_req(input int k, output int cnt);
        cnt = 0;
        repeat (k)
        begin
            step(1);
            if (req === 1'b1)
                cnt++;
        end
    endtask : count_req

    task automatic close_for(input logic [7:0] len, output int cnt);
        @(posedge clock);
        close_len <= len;
        close_go <= 1'b1;
        @(posedge clock);
        close_go <= 1'b0;
        count_req(int'(len) + 8, cnt);
    endtask : close_for

    task automatic hold(input int k, output int cnt);
        @(posedge clock);
        btn_a <= 1'b1;
        btn_b <= 1'b1;
        count_req(k, cnt);
        @(posedge clock);
        btn_a <= 1'b0;
        btn_b <= 1'b0;
        step(4);
    endtask : hold

    // Every state as turn-on, next one as turn-off
    task automatic s_basic();
        for (int s = 0; s < 5; s++)
        begin
            @(posedge clock);
            cfg[0] <= mk({1'b0, 3'(s)}, {1'b0, 3'((s + 1) % 5)}, 15'h0000);
            go(st(s + 4));
            check_bit(outs[0], 1'b0);
            go(st(s));
            check_bit(outs[0], 1'b1);
            check_bit(inds[0], 1'b1);
            go(st(s + 2));
            check_bit(outs[0], 1'b1);
            go(st(s + 1));
            check_bit(outs[0], 1'b0);
            check_bit(inds[0], 1'b0);
        end
    endtask : s_basic

    // On only while running, off at any other state
    task automatic s_invert();
        @(posedge clock);
        cfg[0] <= mk(4'h1, 4'h9, 15'h0000);
        go(timer_out_pkg::paused_state);
        check_bit(outs[0], 1'b0);
        go(timer_out_pkg::running_state);
        check_bit(outs[0], 1'b1);
        go(timer_out_pkg::restart_delay_state);
        check_bit(outs[0], 1'b0);
    endtask : s_invert

    task automatic s_enable();
        @(posedge clock);
        cfg[0] <= mk(4'h1, 4'h4, 15'h0000);
        go(timer_out_pkg::running_state);
        @(posedge clock);
        cfg[0].enable <= 1'b0;
        step(3);
        check_bit(outs[0], 1'b0);
        @(posedge clock);
        cfg[0].enable <= 1'b1;
        step(3);
        check_bit(outs[0], 1'b1);
        go(timer_out_pkg::complete_state);
    endtask : s_enable

    // Two second delay, then a turn-off that cancels a pending one
    task automatic s_delay();
        @(posedge clock);
        cfg[0] <= mk(4'h1, 4'h4, 15'h0002);
        go(timer_out_pkg::running_state);
        wait_out(0, 1'b1, 30, n);
        check_bit(n >= 6 && n <= 20, 1'b1);
        go(timer_out_pkg::complete_state);
        go(timer_out_pkg::running_state);
        step(2);
        go(timer_out_pkg::complete_state);
        step(30);
        check_bit(outs[0], 1'b0);
    endtask : s_delay

    // Three outputs with unlike settings at once
    task automatic s_outputs();
        @(posedge clock);
        cfg[0] <= mk(4'h1, 4'h4, 15'h0000);
        cfg[1] <= mk(4'h8, 4'h0, 15'h0000);
        cfg[2] <= mk(4'h2, 4'h1, 15'h0001);
        go(timer_out_pkg::reset_state);
        go(timer_out_pkg::running_state);
        check_bit(outs[1], 1'b1);
        check_bit(inds[1], 1'b1);
        check_bit(outs[2], 1'b0);
        go(timer_out_pkg::paused_state);
        wait_out(2, 1'b1, 15, n);
        go(timer_out_pkg::reset_state);
        check_bit(outs[0], 1'b1);
        check_bit(inds[1], 1'b0);
        check_bit(inds[2], 1'b1);
        @(posedge clock);
        fitted <= 2'h0;
        step(3);
        check_bit(outs[2], 1'b0);
        @(posedge clock);
        fitted <= 2'h3;
    endtask : s_outputs

    // Just short of and just past each qualify time
    task automatic s_contact();
        for (int m = 0; m < 2; m++)
        begin
            @(posedge clock);
            slow_q <= 1'(m);
            close_for(m ? 8'h13 : 8'h03, c);
            check_bit(c == 0, 1'b1);
            close_for(m ? 8'h16 : 8'h06, c);
            check_bit(c == 1, 1'b1);
        end
    endtask : s_contact

    task automatic s_hold();
        go(timer_out_pkg::reset_state);
        @(posedge clock);
        disp <= 1'b0;
        hold(110, c);
        check_bit(c == 0, 1'b1);
        @(posedge clock);
        disp <= 1'b1;
        hold(110, c);
        check_bit(c == 1, 1'b1);
        check_total(32'h00000000);
    endtask : s_hold

    // Run about 3.5 s, then holds that must leave the total alone
    task automatic s_total();
        go(timer_out_pkg::running_state);
        step(32);
        go(timer_out_pkg::paused_state);
        check_total(32'h00000003);
        @(posedge clock);
        gc_en <= 1'b0;
        hold(110, c);
        check_bit(c == 1, 1'b1);
        check_total(32'h00000003);
        @(posedge clock);
        gc_en <= 1'b1;
        loc_en <= 1'b0;
        hold(40, c);
        check_bit(c == 0, 1'b1);
        check_total(32'h00000003);
    endtask : s_total

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        step(3);
        check_total(32'h00000000);
        s_basic();
        s_invert();
        s_enable();
        s_delay();
        s_outputs();
        s_contact();
        s_hold();
        s_total();
        stop_test();
    end
endmodule : timer_state_output_control_bench
`default_nettype wire
